/* hw/cefl_pkg.sv */
// Package: offsets, field positions, reset values and startup states of the flag latches
package cefl_pkg;

    // Register addresses on the serial register map
    localparam logic [7:0] CEFL_ADDR_CHARGE_EVENT  = 8'h03;
    localparam logic [7:0] CEFL_ADDR_FAULT_EVENT   = 8'h04;
    localparam logic [7:0] CEFL_ADDR_THERM_OPEN    = 8'h05;

    // Values after reset and for unmapped reads
    localparam logic [7:0] CEFL_FLAG_RESET         = 8'h00;
    localparam logic [7:0] CEFL_UNMAPPED_DATA      = 8'h00;

    // Implemented bits per register; all others are reserved
    localparam logic [7:0] CEFL_CHARGE_IMPL        = 8'h7f;
    localparam logic [7:0] CEFL_FAULT_IMPL         = 8'hbf;
    localparam logic [7:0] CEFL_OPEN_IMPL          = 8'h01;

    // Charge event register fields
    localparam int CEFL_BIT_TAPER_ENTRY            = 6;
    localparam int CEFL_BIT_CHARGE_DONE            = 5;
    localparam int CEFL_BIT_INPUT_CURRENT_LIMIT    = 4;
    localparam int CEFL_BIT_POWER_PATH_REG         = 3;
    localparam int CEFL_BIT_INPUT_VOLTAGE_REG      = 2;
    localparam int CEFL_BIT_DIE_TEMP_REG           = 1;
    localparam int CEFL_BIT_INPUT_GOOD_CHANGE      = 0;

    // Fault event register fields
    localparam int CEFL_BIT_INPUT_OVERVOLTAGE      = 7;
    localparam int CEFL_BIT_BATTERY_OVERCURRENT    = 5;
    localparam int CEFL_BIT_BATTERY_UNDERVOLTAGE   = 4;
    localparam int CEFL_BIT_THERMISTOR_COLD        = 3;
    localparam int CEFL_BIT_THERMISTOR_COOL        = 2;
    localparam int CEFL_BIT_THERMISTOR_WARM        = 1;
    localparam int CEFL_BIT_THERMISTOR_HOT         = 0;

    // Thermistor open register field
    localparam int CEFL_BIT_THERMISTOR_OPEN        = 0;

    // Startup sequencer
    typedef enum logic [1:0] {
        CEFL_ST_PRIME = 2'b01,
        CEFL_ST_RUN   = 2'b10
    } cefl_state_t;

endpackage

/* hw/cefl_edge_detect.sv */
// Edge detector for condition levels, primed without events after reset
`timescale 1ns/100ps
module cefl_edge_detect #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Control
    input  wire logic             prime,
    // Levels and edges
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall,
    output logic      [WIDTH-1:0] change
);

    logic [WIDTH-1:0] prev;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            prev <= '0;
        else
            prev <= level;
    end

    // No edges while priming: the first sample only seeds the history
    always_comb
    begin
        rise   = prime ? '0 : (level & ~prev);
        fall   = prime ? '0 : (~level & prev);
        change = prime ? '0 : (level ^ prev);
    end

endmodule // cefl_edge_detect

/* hw/cefl_flag_latch.sv */
// One clear-on-read flag register with reserved bits held at zero
`timescale 1ns/100ps
module cefl_flag_latch
    import cefl_pkg::*;
#(
    parameter int               WIDTH = 8,
    parameter logic [WIDTH-1:0] IMPL  = '1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Events and clear
    input  wire logic [WIDTH-1:0] set,
    input  wire logic             clr,
    // Flags
    output logic      [WIDTH-1:0] q,
    output logic      [WIDTH-1:0] newly
);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            q <= CEFL_FLAG_RESET[WIDTH-1:0];
        else
            q <= (clr ? '0 : q) | (set & IMPL);
    end

    always_comb
    begin
        newly = set & IMPL & ~q;
    end

endmodule // cefl_flag_latch

/* hw/cefl_flag_top.sv */
// Charger event flag latches: three clear-on-read registers and masked event request
`timescale 1ns/100ps

// Notes on behaviour
// - Charge event register at 0x3, resets to zero, clears on read.
// - Bit 6 latches entry into constant-voltage taper charging.
// - Bit 5 latches charge termination.
// - Bit 4 latches input current limit becoming active.
// - Bit 3 latches power-path regulation becoming active.
// - Bit 2 latches input-voltage regulation becoming active, else reads 0.
// - Bit 1 latches die temperature regulation becoming active.
// - Bit 0 latches any change of input good status.
// - Powering up with input good and battery below lockout sends no interrupt.
// - Fault event register at 0x4, resets to zero, clears on read.
// - Bit 7 latches input overvoltage detection.
// - Bit 5 latches battery overcurrent detection.
// - Bit 4 reports battery undervoltage; polarity chosen by parameter.
// - Bit 3 latches thermistor cold region entry.
// - Bit 2 latches thermistor cool region entry.
// - Bit 1 latches thermistor warm region entry.
// - Bit 0 latches thermistor hot region entry.
// - Thermistor open register at 0x5, resets to zero, clears on read.
// - Bit 0 latches an open thermistor fault.
// - Mask bit 1 blocks that flag's interrupt; 0 lets it through.
module cefl_flag_top
    import cefl_pkg::*;
#(
    parameter int FLAG_WIDTH       = 8,
    parameter bit UVLO_FLAG_INVERT = 1'b0
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // Charging and power-path condition levels
    input  wire logic                  taper_active,
    input  wire logic                  charge_done,
    input  wire logic                  input_current_limit_active,
    input  wire logic                  power_path_regulation_active,
    input  wire logic                  input_voltage_regulation_active,
    input  wire logic                  die_temperature_regulation_active,
    input  wire logic                  input_good,
    // Fault condition levels
    input  wire logic                  input_overvoltage,
    input  wire logic                  battery_overcurrent,
    input  wire logic                  battery_lockout_level,
    input  wire logic                  thermistor_cold,
    input  wire logic                  thermistor_cool,
    input  wire logic                  thermistor_warm,
    input  wire logic                  thermistor_hot,
    input  wire logic                  thermistor_open,
    // Interrupt mask bits from the mask registers
    input  wire logic [FLAG_WIDTH-1:0] charge_event_mask,
    input  wire logic [FLAG_WIDTH-1:0] fault_event_mask,
    input  wire logic [FLAG_WIDTH-1:0] thermistor_open_mask,
    // Register read port
    input  wire logic                  rd_strobe,
    input  wire logic [7:0]            rd_addr,
    output logic      [FLAG_WIDTH-1:0] rd_data,
    output logic                       rd_valid,
    // Toward the interrupt output
    output logic                       irq_event,
    output logic                       irq_pending
);

    cefl_state_t           state;
    logic                  prime;
    logic                  pg_irq_block;
    logic [FLAG_WIDTH-1:0] charge_level;
    logic [FLAG_WIDTH-1:0] fault_level;
    logic [FLAG_WIDTH-1:0] open_level;
    logic [FLAG_WIDTH-1:0] charge_rise;
    logic [FLAG_WIDTH-1:0] charge_change;
    logic [FLAG_WIDTH-1:0] fault_rise;
    logic [FLAG_WIDTH-1:0] fault_fall;
    logic [FLAG_WIDTH-1:0] open_rise;
    logic [FLAG_WIDTH-1:0] charge_set;
    logic [FLAG_WIDTH-1:0] fault_set;
    logic [FLAG_WIDTH-1:0] open_set;
    logic [FLAG_WIDTH-1:0] charge_event_flags;
    logic [FLAG_WIDTH-1:0] fault_event_flags;
    logic [FLAG_WIDTH-1:0] thermistor_open_flags;
    logic [FLAG_WIDTH-1:0] charge_newly;
    logic [FLAG_WIDTH-1:0] fault_newly;
    logic [FLAG_WIDTH-1:0] open_newly;
    logic [FLAG_WIDTH-1:0] charge_irq_mask;
    logic                  rd_charge;
    logic                  rd_fault;
    logic                  rd_open;
    logic [FLAG_WIDTH-1:0] next_rd_data;
    logic                  next_irq_event;
    logic                  next_irq_pending;

    // Register select: strobe qualified by its address
    function automatic logic rd_hit(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return strobe && (addr == target);
    endfunction

    // Any latched or new flag whose mask bit is clear
    function automatic logic masked_any(
        input logic [FLAG_WIDTH-1:0] flags,
        input logic [FLAG_WIDTH-1:0] mask
    );
        return |(flags & ~mask);
    endfunction

    // Startup: first cycle after reset seeds edge history
    // Levels already present at reset therefore raise no flag
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            state <= CEFL_ST_PRIME;
        else
        begin
            case (state)
                CEFL_ST_PRIME: state <= CEFL_ST_RUN;
                CEFL_ST_RUN:   state <= CEFL_ST_RUN;
                default:       state <= CEFL_ST_PRIME;
            endcase
        end
    end

    assign prime = (state != CEFL_ST_RUN);

    // Input good at power-up with a low battery: hold off its interrupt
    // Hold ends once the battery climbs above lockout; the flag still latches
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            pg_irq_block <= 1'b0;
        else if (prime)
            pg_irq_block <= input_good & battery_lockout_level;
        else if (!battery_lockout_level)
            pg_irq_block <= 1'b0;
    end

    // Condition levels in register bit order
    always_comb
    begin
        charge_level = '0;
        charge_level[CEFL_BIT_TAPER_ENTRY]         = taper_active;
        charge_level[CEFL_BIT_CHARGE_DONE]         = charge_done;
        charge_level[CEFL_BIT_INPUT_CURRENT_LIMIT] = input_current_limit_active;
        charge_level[CEFL_BIT_POWER_PATH_REG]      = power_path_regulation_active;
        charge_level[CEFL_BIT_INPUT_VOLTAGE_REG]   = input_voltage_regulation_active;
        charge_level[CEFL_BIT_DIE_TEMP_REG]        = die_temperature_regulation_active;
        charge_level[CEFL_BIT_INPUT_GOOD_CHANGE]   = input_good;
        fault_level = '0;
        fault_level[CEFL_BIT_INPUT_OVERVOLTAGE]    = input_overvoltage;
        fault_level[CEFL_BIT_BATTERY_OVERCURRENT]  = battery_overcurrent;
        fault_level[CEFL_BIT_BATTERY_UNDERVOLTAGE] = battery_lockout_level;
        fault_level[CEFL_BIT_THERMISTOR_COLD]      = thermistor_cold;
        fault_level[CEFL_BIT_THERMISTOR_COOL]      = thermistor_cool;
        fault_level[CEFL_BIT_THERMISTOR_WARM]      = thermistor_warm;
        fault_level[CEFL_BIT_THERMISTOR_HOT]       = thermistor_hot;
        open_level = '0;
        open_level[CEFL_BIT_THERMISTOR_OPEN]       = thermistor_open;
    end

    // Edge history per register; only the polarities in use are wired
    cefl_edge_detect #(
        .WIDTH (FLAG_WIDTH)
    ) u_charge_edges (
        .clock   (clock),
        .sys_rst (sys_rst),
        .prime   (prime),
        .level   (charge_level),
        .rise    (charge_rise),
        .fall    (),
        .change  (charge_change)
    );

    cefl_edge_detect #(
        .WIDTH (FLAG_WIDTH)
    ) u_fault_edges (
        .clock   (clock),
        .sys_rst (sys_rst),
        .prime   (prime),
        .level   (fault_level),
        .rise    (fault_rise),
        .fall    (fault_fall),
        .change  ()
    );

    cefl_edge_detect #(
        .WIDTH (FLAG_WIDTH)
    ) u_open_edges (
        .clock   (clock),
        .sys_rst (sys_rst),
        .prime   (prime),
        .level   (open_level),
        .rise    (open_rise),
        .fall    (),
        .change  ()
    );

    // Event selection per field
    always_comb
    begin
        charge_set = '0;
        charge_set[CEFL_BIT_TAPER_ENTRY]         = charge_rise[CEFL_BIT_TAPER_ENTRY];
        charge_set[CEFL_BIT_CHARGE_DONE]         = charge_rise[CEFL_BIT_CHARGE_DONE];
        charge_set[CEFL_BIT_INPUT_CURRENT_LIMIT] =
            charge_rise[CEFL_BIT_INPUT_CURRENT_LIMIT];
        charge_set[CEFL_BIT_POWER_PATH_REG]      = charge_rise[CEFL_BIT_POWER_PATH_REG];
        charge_set[CEFL_BIT_INPUT_VOLTAGE_REG]   =
            charge_rise[CEFL_BIT_INPUT_VOLTAGE_REG];
        charge_set[CEFL_BIT_DIE_TEMP_REG]        = charge_rise[CEFL_BIT_DIE_TEMP_REG];
        charge_set[CEFL_BIT_INPUT_GOOD_CHANGE]   =
            charge_change[CEFL_BIT_INPUT_GOOD_CHANGE];
        fault_set = '0;
        fault_set[CEFL_BIT_INPUT_OVERVOLTAGE]    = fault_rise[CEFL_BIT_INPUT_OVERVOLTAGE];
        fault_set[CEFL_BIT_BATTERY_OVERCURRENT]  =
            fault_rise[CEFL_BIT_BATTERY_OVERCURRENT];
        // Battery lockout: entry by default, recovery when inverted
        fault_set[CEFL_BIT_BATTERY_UNDERVOLTAGE] = UVLO_FLAG_INVERT ?
            fault_fall[CEFL_BIT_BATTERY_UNDERVOLTAGE] :
            fault_rise[CEFL_BIT_BATTERY_UNDERVOLTAGE];
        fault_set[CEFL_BIT_THERMISTOR_COLD]      = fault_rise[CEFL_BIT_THERMISTOR_COLD];
        fault_set[CEFL_BIT_THERMISTOR_COOL]      = fault_rise[CEFL_BIT_THERMISTOR_COOL];
        fault_set[CEFL_BIT_THERMISTOR_WARM]      = fault_rise[CEFL_BIT_THERMISTOR_WARM];
        fault_set[CEFL_BIT_THERMISTOR_HOT]       = fault_rise[CEFL_BIT_THERMISTOR_HOT];
        open_set = '0;
        open_set[CEFL_BIT_THERMISTOR_OPEN]       = open_rise[CEFL_BIT_THERMISTOR_OPEN];
    end

    // Read decode
    assign rd_charge = rd_hit(rd_strobe, rd_addr, CEFL_ADDR_CHARGE_EVENT);
    assign rd_fault  = rd_hit(rd_strobe, rd_addr, CEFL_ADDR_FAULT_EVENT);
    assign rd_open   = rd_hit(rd_strobe, rd_addr, CEFL_ADDR_THERM_OPEN);

    // Set wins over the clearing read; reserved bits never latch
    cefl_flag_latch #(
        .WIDTH (FLAG_WIDTH),
        .IMPL  (CEFL_CHARGE_IMPL[FLAG_WIDTH-1:0])
    ) u_charge_flags (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set     (charge_set),
        .clr     (rd_charge),
        .q       (charge_event_flags),
        .newly   (charge_newly)
    );

    cefl_flag_latch #(
        .WIDTH (FLAG_WIDTH),
        .IMPL  (CEFL_FAULT_IMPL[FLAG_WIDTH-1:0])
    ) u_fault_flags (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set     (fault_set),
        .clr     (rd_fault),
        .q       (fault_event_flags),
        .newly   (fault_newly)
    );

    cefl_flag_latch #(
        .WIDTH (FLAG_WIDTH),
        .IMPL  (CEFL_OPEN_IMPL[FLAG_WIDTH-1:0])
    ) u_open_flags (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set     (open_set),
        .clr     (rd_open),
        .q       (thermistor_open_flags),
        .newly   (open_newly)
    );

    // Read data: value before the clear; unmapped reads give zero
    always_comb
    begin
        if (rd_charge)
            next_rd_data = charge_event_flags;
        else if (rd_fault)
            next_rd_data = fault_event_flags;
        else if (rd_open)
            next_rd_data = thermistor_open_flags;
        else
            next_rd_data = CEFL_UNMAPPED_DATA[FLAG_WIDTH-1:0];
    end

    // Read answer: data held until the next read, valid for one cycle
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            rd_data <= CEFL_FLAG_RESET[FLAG_WIDTH-1:0];
        else if (rd_strobe)
            rd_data <= next_rd_data;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            rd_valid <= 1'b0;
        else
            rd_valid <= rd_strobe;
    end

    // Input good change kept off the request while the power-up hold stands
    always_comb
    begin
        charge_irq_mask = charge_event_mask;
        charge_irq_mask[CEFL_BIT_INPUT_GOOD_CHANGE] =
            charge_event_mask[CEFL_BIT_INPUT_GOOD_CHANGE] | pg_irq_block;
    end

    // Masked interrupt request
    always_comb
    begin
        next_irq_event = masked_any(charge_newly, charge_irq_mask)
                       | masked_any(fault_newly, fault_event_mask)
                       | masked_any(open_newly, thermistor_open_mask);
        next_irq_pending = masked_any(charge_event_flags, charge_irq_mask)
                         | masked_any(fault_event_flags, fault_event_mask)
                         | masked_any(thermistor_open_flags, thermistor_open_mask);
    end

    // Pulse on a fresh unmasked flag; pending follows the latched flags a cycle later
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            irq_event <= 1'b0;
        else
            irq_event <= next_irq_event;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            irq_pending <= 1'b0;
        else
            irq_pending <= next_irq_pending;
    end

endmodule // cefl_flag_top

/* dv/cefl_host_model.sv */
// Host processor model issuing register reads
`timescale 1ns/100ps
module cefl_host_model (
    // Clock
    input  wire logic       clock,
    // Read port
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output logic            rd_strobe,
    output logic [7:0]      rd_addr
);
    initial
    begin
        rd_strobe = 1'b0;
        rd_addr   = 8'h00;
    end

    // Called at a clock edge; one-cycle request, address scrambled once released
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        rd_strobe <= 1'b1;
        rd_addr   <= a;
        @(posedge clock);
        rd_strobe <= 1'b0;
        rd_addr   <= ~a;
        d = 8'hxx;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            if (rd_valid === 1'b1)
            begin
                d = rd_data;
                break;
            end
        end
    endtask
endmodule // cefl_host_model

/* dv/cefl_flag_properties.sv */
// Concurrent checks on the flag read port and event request
`timescale 1ns/100ps
module cefl_flag_properties
    import cefl_pkg::*;
#(
    parameter int FLAG_WIDTH = 8
) (
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  sys_rst,
    // Masks
    input wire logic [FLAG_WIDTH-1:0] charge_event_mask,
    input wire logic [FLAG_WIDTH-1:0] fault_event_mask,
    input wire logic [FLAG_WIDTH-1:0] thermistor_open_mask,
    // Read port
    input wire logic                  rd_strobe,
    input wire logic [7:0]            rd_addr,
    input wire logic [FLAG_WIDTH-1:0] rd_data,
    input wire logic                  rd_valid,
    // Event request
    input wire logic                  irq_event,
    input wire logic                  irq_pending
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic mapped;
    logic all_masked;
    assign mapped = rd_addr inside {CEFL_ADDR_CHARGE_EVENT, CEFL_ADDR_FAULT_EVENT,
                                    CEFL_ADDR_THERM_OPEN};
    assign all_masked = &charge_event_mask && &fault_event_mask && &thermistor_open_mask;

    read_answer_a: assert property (rd_strobe |=> rd_valid)
        else $error("read not answered next cycle");
    valid_only_a: assert property (!rd_strobe |=> !rd_valid)
        else $error("read answer without request");
    unmapped_zero_a: assert property (rd_strobe && !mapped
        |=> rd_data == CEFL_UNMAPPED_DATA)
        else $error("unmapped read not zero");
    charge_rsvd_a: assert property (rd_strobe && rd_addr == CEFL_ADDR_CHARGE_EVENT
        |=> (rd_data & ~CEFL_CHARGE_IMPL) == 8'h00)
        else $error("charge register reserved bit set");
    fault_rsvd_a: assert property (rd_strobe && rd_addr == CEFL_ADDR_FAULT_EVENT
        |=> (rd_data & ~CEFL_FAULT_IMPL) == 8'h00)
        else $error("fault register reserved bit set");
    open_rsvd_a: assert property (rd_strobe && rd_addr == CEFL_ADDR_THERM_OPEN
        |=> (rd_data & ~CEFL_OPEN_IMPL) == 8'h00)
        else $error("open register reserved bit set");
    data_hold_a: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data moved between reads");
    mask_all_a: assert property (all_masked [*3] |-> !irq_event && !irq_pending)
        else $error("masked flag raised request");
    prime_quiet_a: assert property ($fell(sys_rst)
        |-> !irq_event && !irq_pending ##1 !irq_event)
        else $error("request during priming");
    event_pending_a: assert property (irq_event |=> irq_pending)
        else $error("event pulse without pending");

    cover property (rd_valid && rd_data != 8'h00);
    cover property (irq_event);
    cover property (rd_strobe && !mapped);
endmodule // cefl_flag_properties

bind cefl_flag_top cefl_flag_properties #(.FLAG_WIDTH(FLAG_WIDTH)) u_cefl_flag_properties (
    .clock(clock), .sys_rst(sys_rst), .charge_event_mask(charge_event_mask),
    .fault_event_mask(fault_event_mask), .thermistor_open_mask(thermistor_open_mask),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .irq_event(irq_event), .irq_pending(irq_pending)
);

/* dv/tb_top.sv */
// Self-checking bench for the charger event flag latches
`timescale 1ns/100ps
module tb_top;
    import cefl_pkg::*;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [14:0] cond = '0;
    logic [7:0]  charge_event_mask = '0;
    logic [7:0]  fault_event_mask = '0;
    logic [7:0]  thermistor_open_mask = '0;
    logic        rd_strobe;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        irq_event;
    logic        irq_pending;
    logic [7:0]  rv;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cycles = 0;

    initial forever #50 clock = ~clock;

    cefl_flag_top u_cefl_flag_top (
        .clock(clock), .sys_rst(sys_rst),
        .input_good(cond[0]), .die_temperature_regulation_active(cond[1]),
        .input_voltage_regulation_active(cond[2]), .power_path_regulation_active(cond[3]),
        .input_current_limit_active(cond[4]), .charge_done(cond[5]), .taper_active(cond[6]),
        .thermistor_hot(cond[7]), .thermistor_warm(cond[8]), .thermistor_cool(cond[9]),
        .thermistor_cold(cond[10]), .battery_lockout_level(cond[11]),
        .battery_overcurrent(cond[12]), .input_overvoltage(cond[13]),
        .thermistor_open(cond[14]), .charge_event_mask(charge_event_mask),
        .fault_event_mask(fault_event_mask), .thermistor_open_mask(thermistor_open_mask),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .irq_event(irq_event), .irq_pending(irq_pending)
    );

    cefl_host_model u_cefl_host_model (
        .clock(clock), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr)
    );

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            n_fail++;
            final_report();
        end
    end

    // Register and field of each condition input
    function automatic logic [7:0] evt_addr(int i);
        return (i < 7) ? CEFL_ADDR_CHARGE_EVENT : (i < 14) ? CEFL_ADDR_FAULT_EVENT
                                                           : CEFL_ADDR_THERM_OPEN;
    endfunction

    function automatic logic [7:0] evt_bits(int i);
        if (i < 12)
            return 8'h01 << ((i < 7) ? i : i - 7);
        return (i == 12) ? 8'h20 : (i == 13) ? 8'h80 : 8'h01;
    endfunction

    task automatic do_reset(logic [14:0] lv);
        @(posedge clock);
        sys_rst <= 1'b1;
        cond    <= lv;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    task automatic s_reset_values;
        for (int a = 3; a < 6; a++)
        begin
            u_cefl_host_model.read(8'(a), rv);
            check("reset value", rv, CEFL_FLAG_RESET);
        end
        u_cefl_host_model.read(8'hff, rv);
        check("unmapped", rv, CEFL_UNMAPPED_DATA);
    endtask

    task automatic s_each_event;
        for (int i = 0; i < 15; i++)
        begin
            cond[i] <= 1'b1;
            repeat (2) @(posedge clock);
            check("irq event", {7'h00, irq_event}, 8'h01);
            @(posedge clock);
            check("irq pending", {6'h00, irq_event, irq_pending}, 8'h01);
            u_cefl_host_model.read(evt_addr(i), rv);
            check("event flag", rv, evt_bits(i));
            u_cefl_host_model.read(evt_addr(i), rv);
            check("flag cleared", rv, 8'h00);
            cond[i] <= 1'b0;
            repeat (3) @(posedge clock);
            u_cefl_host_model.read(evt_addr(i), rv);
            check("level fall", rv, (i == 0) ? 8'h01 : 8'h00);
            repeat (2) @(posedge clock);
        end
    endtask

    task automatic s_latch_hold;
        cond[6] <= 1'b1;
        @(posedge clock);
        cond[6] <= 1'b0;
        repeat (3) @(posedge clock);
        u_cefl_host_model.read(CEFL_ADDR_CHARGE_EVENT, rv);
        check("held flag", rv, 8'h40);
        u_cefl_host_model.read(CEFL_ADDR_CHARGE_EVENT, rv);
        check("held cleared", rv, 8'h00);
    endtask

    // Event lands on the same edge that takes the clearing read
    task automatic s_read_collision;
        cond[5] <= 1'b1;
        u_cefl_host_model.read(CEFL_ADDR_CHARGE_EVENT, rv);
        u_cefl_host_model.read(CEFL_ADDR_CHARGE_EVENT, rv);
        check("set beats clear", rv, 8'h20);
        cond[5] <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic s_mask;
        charge_event_mask    <= 8'hff;
        fault_event_mask     <= 8'hff;
        thermistor_open_mask <= 8'hff;
        @(posedge clock);
        cond[6]  <= 1'b1;
        cond[13] <= 1'b1;
        repeat (4)
        begin
            @(posedge clock);
            check("masked pending", {7'h00, irq_pending}, 8'h00);
        end
        u_cefl_host_model.read(CEFL_ADDR_CHARGE_EVENT, rv);
        check("masked charge flag", rv, 8'h40);
        u_cefl_host_model.read(CEFL_ADDR_FAULT_EVENT, rv);
        check("masked fault flag", rv, 8'h80);
        cond                 <= '0;
        charge_event_mask    <= 8'h00;
        fault_event_mask     <= 8'h00;
        thermistor_open_mask <= 8'h00;
        @(posedge clock);
    endtask

    // Power up with input good and battery below lockout
    task automatic s_power_up;
        do_reset(15'h0801);
        repeat (6)
        begin
            @(posedge clock);
            check("power-up irq", {6'h00, irq_event, irq_pending}, 8'h00);
        end
        cond[0] <= 1'b0;
        repeat (3)
        begin
            @(posedge clock);
            check("held pg irq", {6'h00, irq_event, irq_pending}, 8'h00);
        end
        u_cefl_host_model.read(CEFL_ADDR_CHARGE_EVENT, rv);
        check("held pg flag", rv, 8'h01);
        cond <= '0;
        repeat (3) @(posedge clock);
        for (int a = 3; a < 6; a++)
        begin
            u_cefl_host_model.read(8'(a), rv);
            check("lockout fall", rv, 8'h00);
        end
    endtask

    initial
    begin
        do_reset('0);
        s_reset_values();
        s_each_event();
        s_latch_hold();
        s_read_collision();
        s_mask();
        s_power_up();
        final_report();
    end
endmodule // tb_top
